/* File: pwc_pkg.sv */
package pwc_pkg;
  localparam logic [7:0] PMC_OFS = 8'h00;
  localparam logic [7:0] IRQ_STS_OFS = 8'h04;
  localparam logic [7:0] IRQ_EN_OFS = 8'h08;
  localparam logic [7:0] WAKE_OFS = 8'h0C;
  localparam logic [7:0] PHY_CTL_OFS = 8'h10;
  localparam int READY_POS = 0;
  localparam int PIN_EN_POS = 1;
  localparam int PULSE_SEL_POS = 2;
  localparam int WSS_POS = 4;
  localparam int WFE_POS = 8;
  localparam int EWE_POS = 9;
  localparam int PSF_POS = 12;
  localparam int WAKE_IRQ_POS = 0;
  localparam int PHY_IRQ_POS = 1;
  localparam int PHY_FLAG_POS = 1;
  localparam int PHY_IEN_POS = 2;
  localparam int PHY_GPD_POS = 11;
  localparam int PHY_EPD_POS = 13;
  localparam logic [1:0] PSF_NORMAL = 2'h0;
  localparam logic [1:0] PSF_WOL = 2'h1;
  localparam logic [1:0] PSF_ENERGY = 2'h2;
  localparam logic [1:0] WSS_ENERGY = 2'h1;
  localparam logic [1:0] WSS_FRAME = 2'h2;
  localparam logic READY_RST = 1'h1;
  localparam logic HREADY_RST = 1'h1;
  localparam int CLK_PERIOD_NS = 5;
  localparam int NS_PER_MS = 1000000;
  localparam int RESUME_TIME_MS = 2;
  localparam int PULSE_TIME_MS = 50;
  localparam int RESUME_CYCLES = RESUME_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int PULSE_CYCLES = (PULSE_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHY_RST_CYCLES = 4;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'h0,
    ST_WOL = 2'h1,
    ST_ENERGY = 2'h2,
    ST_RESUME = 2'h3
  } pwc_pm_e;

  typedef struct packed {
    logic mac_clk_en;
    logic host_clk_en;
    logic int_clk_en;
    logic rx_pm_en;
  } pwc_clk_en_t;

  localparam pwc_clk_en_t CLK_ALL_ON = 4'hF;

  typedef struct packed {
    logic gen_pd;
    logic energy_pd;
    logic irq_en;
  } pwc_phy_cfg_t;

  typedef struct packed {
    logic powered;
    logic in_reset;
    logic energy_flag;
  } pwc_phy_sts_t;
endpackage

/* File: pwc_pulse_timer.sv */
`timescale 1ns/1ps
module pwc_pulse_timer #(
  parameter int PULSE_CYC = pwc_pkg::PULSE_CYCLES
) (
  input logic clock_i,
  input logic rst_b_i,
  input logic start_i,
  input logic hold_i,
  output logic active_o
);
  import pwc_pkg::*;
  localparam int CW = $clog2(PULSE_CYC + 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
  } pwc_pulse_state_t;
  pwc_pulse_state_t s;
  pwc_pulse_state_t next_s;

  if (PULSE_CYC < 1) begin : g_bad
    $error("pulse length must be at least one cycle");
  end

  always_comb begin
    next_s = s;
    if (!hold_i) begin
      next_s.cnt = '0;
    end else if (start_i) begin
      next_s.cnt = CW'(PULSE_CYC);
    end else if (s.cnt != '0) begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign active_o = (s.cnt != '0);
endmodule

/* File: pwc_phy_power.sv */
`timescale 1ns/1ps
module pwc_phy_power (
  input logic clock_i,
  input logic rst_b_i,
  input pwc_pkg::pwc_phy_cfg_t cfg_i,
  input logic line_energy_present_i,
  input logic flag_clr_i,
  output pwc_pkg::pwc_phy_sts_t sts_o
);
  import pwc_pkg::*;
  typedef struct packed {
    pwc_phy_sts_t sts;
    logic [2:0] rst_cnt;
    logic prev_gpd;
    logic prev_energy;
  } pwc_phy_state_t;
  pwc_phy_state_t s;
  pwc_phy_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.prev_gpd = cfg_i.gen_pd;
    next_s.prev_energy = line_energy_present_i;
    // general power-down keeps only management alive
    next_s.sts.powered = !cfg_i.gen_pd && !(cfg_i.energy_pd && !line_energy_present_i);
    if (s.prev_gpd && !cfg_i.gen_pd) begin
      next_s.rst_cnt = 3'(PHY_RST_CYCLES);
    end else if (s.rst_cnt != 3'h0) begin
      next_s.rst_cnt = s.rst_cnt - 3'h1;
    end
    next_s.sts.in_reset = (next_s.rst_cnt != 3'h0);
    if (flag_clr_i) begin
      next_s.sts.energy_flag = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (cfg_i.energy_pd && line_energy_present_i && !s.prev_energy) begin
      next_s.sts.energy_flag = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      s <= '0;
      s.sts.powered <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign sts_o = s.sts;
endmodule

/* File: pwc_ctrl.sv */
`timescale 1ns/1ps
// Contract
// - in sleep, only the power control register reads back; others read zero
// - ready flag clear in both sleep states, set again only back in normal
// - writes are ignored until one read after reset or return from sleep
// - wake write in sleep returns to normal and resets the power-state field
// - power-state 01 enters wake-on-frame sleep and clears ready
// - wake-on-frame sleep keeps internal clock and receive wake logic, stops MAC/host
// - frame detection auto-enabled in that sleep; pin needs frame and pin enables
// - frame detection loads wake source 10 and may raise the host interrupt
// - wake interrupt flag sets on any internal wake event, pin enable aside
// - energy sleep stops MAC, host and internal clocks and clears ready
// - energy sleep with both enables: carrier drives pin, loads source 01, immediately
// - wake flag held while event persists, then cleared by writing one
// - host interrupt on wake event regardless of pin enable or pin level
// - pulse select one gives a 50 ms pin pulse, zero a steady level
// - pin drops when source, matching wake enable or pin enable is cleared
// - PHY general power-down holds while its bit is set; clearing resets PHY
// - PHY energy power-down sleeps without energy, wakes on energy, sets flag
// - first one or two packets during energy wake may be lost
// - configuration kept across both sleep states
// - ready set within 2 ms after the wake write
module pwc_ctrl #(
  parameter int RESUME_CYC = pwc_pkg::RESUME_CYCLES,
  parameter int PULSE_CYC = pwc_pkg::PULSE_CYCLES
) (
  input logic clock_i,
  input logic rst_b_i,
  input logic hsel_i,
  input logic [31:0] haddr_i,
  input logic [1:0] htrans_i,
  input logic hwrite_i,
  input logic [2:0] hsize_i,
  input logic [31:0] hwdata_i,
  input logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input logic wake_frame_i,
  input logic line_energy_present_i,
  output logic wake_pin_o,
  output logic irq_o,
  output pwc_pkg::pwc_clk_en_t clk_en_o,
  output logic phy_powered_o,
  output logic phy_reset_o
);
  import pwc_pkg::*;
  localparam int RCW = $clog2(RESUME_CYC + 1);

  if (RESUME_CYC < 1 || PULSE_CYC < 1) begin : g_bad
    $error("resume and pulse counts must be at least one cycle");
  end

  typedef struct packed {
    pwc_pm_e pm;
    logic [1:0] psf;
    logic ready;
    logic read_seen;
    logic pin_en;
    logic pulse_sel;
    logic wfe;
    logic ewe;
    logic [1:0] wss;
    logic wake_irq;
    logic [1:0] irq_en;
    pwc_phy_cfg_t phy_cfg;
    logic phy_flag_clr;
    logic [RCW-1:0] rcnt;
    logic gate_prev;
    logic pulse_start;
    logic pin;
    logic irq;
    pwc_clk_en_t clk_en;
    logic ph_act;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic hready_out;
  } pwc_ctrl_state_t;

  pwc_ctrl_state_t s;
  pwc_ctrl_state_t next_s;
  pwc_phy_sts_t phy_sts;
  logic pulse_active;
  logic take;
  logic in_sleep;
  logic pme_event;
  logic pin_gate;
  logic wr_ok;

  function automatic logic [31:0] pmc_word(input pwc_ctrl_state_t st);
    logic [31:0] w;
    w = 32'h0;
    w[READY_POS] = st.ready;
    w[PIN_EN_POS] = st.pin_en;
    w[PULSE_SEL_POS] = st.pulse_sel;
    w[WSS_POS+:2] = st.wss;
    w[WFE_POS] = st.wfe;
    w[EWE_POS] = st.ewe;
    w[PSF_POS+:2] = st.psf;
    return w;
  endfunction

  function automatic logic [1:0] irq_vec(input pwc_ctrl_state_t st, input pwc_phy_sts_t ps);
    logic [1:0] v;
    v = 2'h0;
    v[WAKE_IRQ_POS] = st.wake_irq;
    v[PHY_IRQ_POS] = ps.energy_flag;
    return v;
  endfunction

  function automatic pwc_clk_en_t clk_of(input pwc_pm_e pm);
    pwc_clk_en_t c;
    c = CLK_ALL_ON;
    case (pm)
      ST_WOL: begin
        c.mac_clk_en = 1'b0;
        c.host_clk_en = 1'b0;
      end
      ST_ENERGY: begin
        c = '0;
      end
      default: begin
        c = CLK_ALL_ON;
      end
    endcase
    return c;
  endfunction

  function automatic logic [31:0] rd_word(input pwc_ctrl_state_t st, input pwc_phy_sts_t ps,
                                          input logic [31:0] addr);
    logic [31:0] w;
    w = 32'h0;
    if (addr[31:8] == 24'h0) begin
      case (addr[7:0])
        PMC_OFS: w = pmc_word(st);
        IRQ_STS_OFS: w[1:0] = irq_vec(st, ps);
        IRQ_EN_OFS: w[1:0] = st.irq_en;
        PHY_CTL_OFS: begin
          w[PHY_FLAG_POS] = ps.energy_flag;
          w[PHY_IEN_POS] = st.phy_cfg.irq_en;
          w[PHY_GPD_POS] = st.phy_cfg.gen_pd;
          w[PHY_EPD_POS] = st.phy_cfg.energy_pd;
        end
        default: w = 32'h0;
      endcase
    end
    return w;
  endfunction

  assign take = hsel_i && htrans_i[1] && hready_i;
  assign in_sleep = (s.pm == ST_WOL) || (s.pm == ST_ENERGY);
  assign pme_event = (s.wss == WSS_FRAME && s.wfe) || (s.wss == WSS_ENERGY && s.ewe);
  assign pin_gate = s.pin_en && pme_event;
  assign wr_ok = s.ph_act && s.ph_write && s.read_seen;

  always_comb begin
    next_s = s;
    next_s.phy_flag_clr = 1'b0;
    next_s.hready_out = 1'b1;
    next_s.ph_act = take;
    next_s.ph_write = hwrite_i;
    next_s.ph_addr = haddr_i[7:0];
    if (take && !hwrite_i) begin
      next_s.read_seen = 1'b1;
      if (!s.ready && haddr_i != {24'h0, PMC_OFS}) begin
        next_s.rdata = 32'h0;
      end else begin
        next_s.rdata = rd_word(s, phy_sts, haddr_i);
      end
    end
    if (wr_ok && s.ph_addr == WAKE_OFS && in_sleep) begin
      next_s.pm = ST_RESUME;
      next_s.psf = PSF_NORMAL;
      next_s.rcnt = '0;
    end
    // every other write needs the normal state with ready set
    if (wr_ok && s.ready && s.pm == ST_NORMAL) begin
      case (s.ph_addr)
        PMC_OFS: begin
          next_s.pin_en = hwdata_i[PIN_EN_POS];
          next_s.pulse_sel = hwdata_i[PULSE_SEL_POS];
          next_s.wfe = hwdata_i[WFE_POS];
          next_s.ewe = hwdata_i[EWE_POS];
          next_s.wss = s.wss & ~hwdata_i[WSS_POS+:2];
          next_s.psf = hwdata_i[PSF_POS+:2];
          if (hwdata_i[PSF_POS+:2] == PSF_WOL) begin
            next_s.pm = ST_WOL;
            next_s.ready = 1'b0;
          end else if (hwdata_i[PSF_POS+:2] == PSF_ENERGY) begin
            next_s.pm = ST_ENERGY;
            next_s.ready = 1'b0;
          end else begin
            next_s.psf = PSF_NORMAL;
          end
        end
        IRQ_STS_OFS: begin
          if (hwdata_i[WAKE_IRQ_POS]) begin
            next_s.wake_irq = 1'b0;
          end
          next_s.phy_flag_clr = hwdata_i[PHY_IRQ_POS];
        end
        IRQ_EN_OFS: next_s.irq_en = hwdata_i[1:0];
        PHY_CTL_OFS: begin
          next_s.phy_cfg.gen_pd = hwdata_i[PHY_GPD_POS];
          next_s.phy_cfg.energy_pd = hwdata_i[PHY_EPD_POS];
          next_s.phy_cfg.irq_en = hwdata_i[PHY_IEN_POS];
          next_s.phy_flag_clr = hwdata_i[PHY_FLAG_POS];
        end
        default: begin
          next_s.irq_en = s.irq_en;
        end
      endcase
    end
    // detection stays live in sleep; settings persist untouched
    if (s.pm == ST_WOL && wake_frame_i) begin
      next_s.wss = WSS_FRAME;
    end
    // level input, so carrier present at entry hits on the first cycle
    if (s.pm == ST_ENERGY && s.ewe && line_energy_present_i) begin
      next_s.wss = WSS_ENERGY;
    end
    if (s.pm == ST_RESUME) begin
      if (s.rcnt == RCW'(RESUME_CYC - 1)) begin
        next_s.pm = ST_NORMAL;
        next_s.ready = 1'b1;
        next_s.read_seen = 1'b0;
      end else begin
        next_s.rcnt = s.rcnt + 1'b1;
      end
    end
    if (pme_event) begin
      next_s.wake_irq = 1'b1;
    end
    next_s.gate_prev = pin_gate;
    next_s.pulse_start = pin_gate && !s.gate_prev && s.pulse_sel;
    next_s.pin = pin_gate && (s.pulse_sel ? pulse_active : 1'b1);
    next_s.irq = |(irq_vec(s, phy_sts) & s.irq_en);
    next_s.clk_en = clk_of(s.pm);
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      s <= '0;
      s.ready <= READY_RST;
      s.hready_out <= HREADY_RST;
      s.clk_en <= CLK_ALL_ON;
    end else begin
      s <= next_s;
    end
  end

  pwc_pulse_timer #(
    .PULSE_CYC(PULSE_CYC)
  ) u_pulse (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .start_i(s.pulse_start),
    .hold_i(pin_gate && s.pulse_sel),
    .active_o(pulse_active)
  );

  pwc_phy_power u_phy (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .cfg_i(s.phy_cfg),
    .line_energy_present_i(line_energy_present_i),
    .flag_clr_i(s.phy_flag_clr),
    .sts_o(phy_sts)
  );

  assign hrdata_o = s.rdata;
  assign hreadyout_o = s.hready_out;
  assign hresp_o = 1'b0;
  assign wake_pin_o = s.pin;
  assign irq_o = s.irq;
  assign clk_en_o = s.clk_en;
  assign phy_powered_o = phy_sts.powered;
  assign phy_reset_o = phy_sts.in_reset;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  a_sleep_read_gate: assert property ((take && !hwrite_i && in_sleep &&
    haddr_i != {24'h0, PMC_OFS}) |=> (hrdata_o == 32'h0))
    else $error("non-control register readable in sleep");
  a_ready_sleep: assert property (in_sleep |-> !s.ready)
    else $error("ready set while asleep");
  a_write_before_read: assert property ((s.ph_act && s.ph_write && !s.read_seen) |=>
    ($stable(s.irq_en) && $stable(s.phy_cfg) && $stable(s.pin_en)))
    else $error("write took effect before a read");
  a_wake_write: assert property ((wr_ok && s.ph_addr == WAKE_OFS && in_sleep) |=>
    (s.pm == ST_RESUME && s.psf == PSF_NORMAL))
    else $error("wake write did not leave sleep");
  a_wol_entry: assert property ((wr_ok && s.ready && s.pm == ST_NORMAL &&
    s.ph_addr == PMC_OFS && hwdata_i[PSF_POS+:2] == PSF_WOL) |=>
    (s.pm == ST_WOL && !s.ready) ##1 (clk_en_o == 4'h3))
    else $error("wake-on-frame entry wrong");
  a_frame_source: assert property ((s.pm == ST_WOL && wake_frame_i) |=>
    (s.wss == WSS_FRAME))
    else $error("frame detection did not load source");
  a_energy_clocks: assert property ((s.pm == ST_ENERGY) |=> (clk_en_o == 4'h0))
    else $error("clocks running in energy sleep");
  a_energy_source: assert property ((s.pm == ST_ENERGY && s.ewe &&
    line_energy_present_i) |=> (s.wss == WSS_ENERGY))
    else $error("carrier did not load source");
  a_flag_hold: assert property (pme_event |=> s.wake_irq)
    else $error("wake flag not held during event");
  a_pin_static: assert property ((pin_gate && !s.pulse_sel) |=> wake_pin_o)
    else $error("static pin not driven");
  a_pin_drop: assert property (!pin_gate |=> !wake_pin_o)
    else $error("pin active without gate");
  a_resume_done: assert property ((s.pm == ST_RESUME && s.rcnt == RCW'(RESUME_CYC - 1))
    |=> (s.ready && s.pm == ST_NORMAL))
    else $error("ready late after wake");
  a_resume_read: assert property ((s.pm == ST_RESUME && s.rcnt == RCW'(RESUME_CYC - 1))
    |=> !s.read_seen)
    else $error("writes enabled without a read after wake");
  a_resume_psf: assert property ((s.pm == ST_RESUME) |-> (s.psf == PSF_NORMAL))
    else $error("power-state field not normal while resuming");
  a_irq_raise: assert property ((s.wake_irq && s.irq_en[WAKE_IRQ_POS]) |=> irq_o)
    else $error("host interrupt missing on wake flag");
  a_source_hold: assert property ((s.wss != 2'h0 &&
    !(wr_ok && s.ready && s.pm == ST_NORMAL && s.ph_addr == PMC_OFS))
    |=> (s.wss != 2'h0))
    else $error("wake source cleared without host");
  // carrier to pin: source loads, then the gated pin register follows
  a_energy_pin: assert property ((s.pm == ST_ENERGY && s.ewe && s.pin_en &&
    !s.pulse_sel && line_energy_present_i) |-> ##2 wake_pin_o)
    else $error("carrier did not drive the pin");

  c_wol_sleep: cover property (s.pm == ST_WOL ##1 s.pm == ST_RESUME);
  c_energy_wake: cover property (s.pm == ST_ENERGY && s.wss == WSS_ENERGY);
  c_pulse_start: cover property (s.pulse_start);
  c_resume_ready: cover property (s.pm == ST_RESUME ##1 s.pm == ST_NORMAL);
  c_static_pin: cover property (wake_pin_o && !s.pulse_sel);
endmodule

/* File: pwc_line_model.sv */
`timescale 1ns/1ps
// line side: receive wake logic and carrier, registered like the real front end
module pwc_line_model (
  input logic clock_i,
  input logic send_frame_i,
  input logic carrier_i,
  output logic wake_frame_o,
  output logic line_energy_present_o
);
  initial wake_frame_o = 1'b0;
  initial line_energy_present_o = 1'b0;
  // one-cycle detect strobe per request
  always_ff @(posedge clock_i) begin
    wake_frame_o <= send_frame_i & ~wake_frame_o;
    line_energy_present_o <= carrier_i;
  end
endmodule

/* File: pwc_ctrl_tb.sv */
`timescale 1ns/1ps
module pwc_ctrl_tb;
  import pwc_pkg::*;
  localparam int RES_CYC = 8;
  localparam int PUL_CYC = 16;
  localparam int LIMIT = 6000;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic send_frame = 1'b0;
  logic carrier = 1'b0;
  logic wake_frame;
  logic line_energy;
  logic wake_pin;
  logic irq;
  pwc_clk_en_t clk_en;
  logic phy_powered;
  logic phy_reset;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] rv;
  int n;

  always #2.5 clock_i = ~clock_i;

  pwc_ctrl #(.RESUME_CYC(RES_CYC), .PULSE_CYC(PUL_CYC)) pwc_ctrl_i (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .wake_frame_i(wake_frame), .line_energy_present_i(line_energy), .wake_pin_o(wake_pin),
    .irq_o(irq), .clk_en_o(clk_en), .phy_powered_o(phy_powered), .phy_reset_o(phy_reset)
  );

  pwc_line_model pwc_line_model_i (
    .clock_i(clock_i), .send_frame_i(send_frame), .carrier_i(carrier),
    .wake_frame_o(wake_frame), .line_energy_present_o(line_energy)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // single AHB-Lite transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clock_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ofs};
    hwrite <= wr;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, ofs, d, x);
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, ofs, 32'h0, x);
    chk(x, exp);
  endtask

  task automatic wake_up();
    logic [31:0] x;
    int i;
    wr(WAKE_OFS, 32'h0);
    x = 32'h0;
    for (i = 0; i < RES_CYC + 4 && x[READY_POS] !== 1'b1; i++) begin
      ahb(1'b0, PMC_OFS, 32'h0, x);
    end
    chk({31'h0, x[READY_POS]}, 32'h1);
  endtask

  task automatic count_high(input int len, ref logic sig, output int cnt);
    int i;
    cnt = 0;
    for (i = 0; i < len; i++) begin
      @(posedge clock_i);
      if (sig === 1'b1) cnt++;
    end
  endtask

  initial begin
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    // writes ignored before the first read
    wr(IRQ_EN_OFS, 32'h3);
    rd(PMC_OFS, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    rd(IRQ_EN_OFS, 32'h0);
    wr(IRQ_EN_OFS, 32'h3);
    rd(IRQ_EN_OFS, 32'h3);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    wr(WAKE_OFS, 32'h0);
    rd(PMC_OFS, 32'h1);
    $display("test basic done");

    // frame sleep, static pin
    wr(PMC_OFS, 32'h1102);
    rd(PMC_OFS, 32'h1102);
    rd(IRQ_EN_OFS, 32'h0);
    wr(IRQ_EN_OFS, 32'h0);
    chk({28'h0, clk_en}, 32'h3);
    @(posedge clock_i) send_frame <= 1'b1;
    @(posedge clock_i) send_frame <= 1'b0;
    repeat (6) @(posedge clock_i);
    rd(PMC_OFS, 32'h1122);
    chk({31'h0, wake_pin}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wake_up();
    rd(PMC_OFS, 32'h0123);
    rd(IRQ_EN_OFS, 32'h3);
    chk({28'h0, clk_en}, {28'h0, CLK_ALL_ON});
    wr(IRQ_STS_OFS, 32'h1);
    rd(IRQ_STS_OFS, 32'h1);
    wr(PMC_OFS, 32'h0122);
    repeat (3) @(posedge clock_i);
    chk({31'h0, wake_pin}, 32'h0);
    wr(IRQ_STS_OFS, 32'h1);
    rd(IRQ_STS_OFS, 32'h0);
    repeat (2) @(posedge clock_i);
    chk({31'h0, irq}, 32'h0);
    $display("test frame sleep done");

    // energy sleep with carrier present at entry, pulsed pin
    wr(PMC_OFS, 32'h0); // clear frame enable and pin enable
    carrier <= 1'b1;
    wr(PHY_CTL_OFS, 32'h2000);
    wr(PMC_OFS, 32'h2206);
    count_high(3 * PUL_CYC, wake_pin, n);
    chk(n, PUL_CYC);
    chk({28'h0, clk_en}, 32'h0);
    rd(PMC_OFS, 32'h2216);
    wake_up();
    rd(PMC_OFS, 32'h0217);
    ahb(1'b0, PHY_CTL_OFS, 32'h0, rv);
    chk({31'h0, rv[PHY_EPD_POS]}, 32'h1);
    wr(PHY_CTL_OFS, 32'h0);
    carrier <= 1'b0;
    wr(PMC_OFS, 32'h0214);
    rd(PMC_OFS, 32'h0205);
    $display("test energy sleep done");

    // PHY general power-down and automatic reset
    wr(PHY_CTL_OFS, 32'h0800);
    repeat (3) @(posedge clock_i);
    chk({31'h0, phy_powered}, 32'h0);
    wr(PHY_CTL_OFS, 32'h0);
    count_high(12, phy_reset, n);
    chk(n, PHY_RST_CYCLES);
    chk({31'h0, phy_powered}, 32'h1);
    $display("test phy power done");

    // reset in mid-run: settings return to reset values, writes need a read again
    @(posedge clock_i) rst_b_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    wr(IRQ_EN_OFS, 32'h3);
    rd(IRQ_EN_OFS, 32'h0);
    rd(PMC_OFS, 32'h1);
    chk({28'h0, clk_en}, {28'h0, CLK_ALL_ON});
    chk({31'h0, wake_pin}, 32'h0);
    $display("test reset done");
    print_verdict();
  end
endmodule
